/* dfs_map.svh */
`ifndef DFS_MAP_SVH
`define DFS_MAP_SVH
`define DFS_SYNC_CMD 8'h55
`define DFS_SYNC_RSP 8'haa
`define DFS_CMD_ERASE_SEC 8'h12
`define DFS_CMD_PROG_SEC 8'h13
`define DFS_RAM_BASE 20'h00000
`define DFS_RAM_LAST 20'h3ffff
`define DFS_FLASH_BASE 20'h80000
`define DFS_FLASH_LAST 20'hfffff
`define DFS_SECTOR_SHIFT 12
`define DFS_SECTOR_BYTES 20'h01000
`define DFS_HDR_LEN 3'h7
`define DFS_ST_OK 16'h0000
`define DFS_ST_BAD_LRC 16'h0001
`define DFS_ST_BAD_CMD 16'h0002
`endif

/* dfs_pkg.sv */
package dfs_pkg;
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] sector;
        logic [15:0] ram_addr;
        logic [15:0] length;
    } dfs_hdr_t;
    typedef struct packed {
        logic erase;
        logic [19:0] flash_addr;
        logic [19:0] flash_bytes;
        logic [19:0] ram_addr;
    } dfs_op_t;
    typedef enum logic [1:0] {DFS_RX_IDLE, DFS_RX_HDR, DFS_RX_PAY, DFS_RX_LRC} dfs_rx_t;
    typedef enum logic [1:0] {DFS_TX_IDLE, DFS_TX_ST, DFS_TX_LRC} dfs_tx_t;
endpackage

/* dfs_addr_map.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dfs_map.svh"
module dfs_addr_map (
    input wire logic [19:0] i_addr,
    output logic o_is_ram,
    output logic o_is_flash
);
    // ------------------------------
    // System map decode
    // ------------------------------
    always_comb begin
        o_is_ram = (i_addr <= `DFS_RAM_LAST);
        o_is_flash = (i_addr >= `DFS_FLASH_BASE);
    end
endmodule
`default_nettype wire

/* dfs_sector_cmd.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dfs_map.svh"
module dfs_sector_cmd (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_rx_ready,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    output logic o_op_valid,
    output dfs_pkg::dfs_op_t o_op,
    input wire logic i_op_ready,
    input wire logic i_op_done,
    input wire logic i_op_fail
);
    // ------------------------------
    // Receive, execution and response state
    // ------------------------------
    dfs_pkg::dfs_rx_t rx_reg;
    dfs_pkg::dfs_tx_t tx_reg;
    logic [2:0] idx_reg;
    logic [15:0] pay_reg;
    logic [7:0] lrc_reg;
    dfs_pkg::dfs_hdr_t hdr_reg;
    logic busy_reg;
    logic [15:0] st_reg;
    logic [1:0] tcnt_reg;
    logic [7:0] tlrc_reg;
    logic [7:0] tx_data_reg;
    logic op_valid_reg;
    dfs_pkg::dfs_op_t op_reg;
    logic rx_take;
    logic tx_take;
    logic is_sec;
    logic ram_ok;
    logic fl_ok;
    logic [19:0] fl_addr;
    logic [19:0] src_addr;

    // Packets are not accepted while one is still being executed or answered
    assign o_rx_ready = !busy_reg;
    assign rx_take = i_rx_valid && o_rx_ready;
    assign tx_take = o_tx_valid && i_tx_ready;
    assign o_tx_valid = (tx_reg != dfs_pkg::DFS_TX_IDLE);
    assign o_tx_data = tx_data_reg;
    assign o_op_valid = op_valid_reg;
    assign o_op = op_reg;

    always_comb begin
        is_sec = (hdr_reg.cmd == `DFS_CMD_ERASE_SEC) || (hdr_reg.cmd == `DFS_CMD_PROG_SEC);
        src_addr = {4'h0, hdr_reg.ram_addr};
        fl_addr = `DFS_FLASH_BASE + {hdr_reg.sector, 12'h000};
        if (hdr_reg.cmd == `DFS_CMD_ERASE_SEC) begin
            fl_addr[`DFS_SECTOR_SHIFT] = 1'b0;
        end
    end

    dfs_addr_map u_src (
        .i_addr(src_addr),
        .o_is_ram(ram_ok),
        .o_is_flash()
    );

    // Sector numbers past the flash size wrap, so the target must still decode as flash
    dfs_addr_map u_fl (
        .i_addr(fl_addr),
        .o_is_ram(),
        .o_is_flash(fl_ok)
    );

    // ------------------------------
    // Packet receiver
    // ------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rx_reg <= dfs_pkg::DFS_RX_IDLE;
            idx_reg <= 3'h0;
            pay_reg <= 16'h0000;
            lrc_reg <= 8'h00;
            hdr_reg <= '0;
        end else if (rx_take) begin
            lrc_reg <= lrc_reg ^ i_rx_data;
            case (rx_reg)
                dfs_pkg::DFS_RX_IDLE: begin
                    lrc_reg <= i_rx_data;
                    idx_reg <= 3'h2;
                    if (i_rx_data == `DFS_SYNC_CMD) begin
                        rx_reg <= dfs_pkg::DFS_RX_HDR;
                    end
                end
                dfs_pkg::DFS_RX_HDR: begin
                    idx_reg <= idx_reg + 3'h1;
                    case (idx_reg)
                        3'h2: hdr_reg.cmd <= i_rx_data;
                        3'h3: hdr_reg.sector <= i_rx_data;
                        3'h4: hdr_reg.ram_addr[15:8] <= i_rx_data;
                        3'h5: hdr_reg.ram_addr[7:0] <= i_rx_data;
                        3'h6: hdr_reg.length[15:8] <= i_rx_data;
                        default: hdr_reg.length[7:0] <= i_rx_data;
                    endcase
                    if (idx_reg == `DFS_HDR_LEN) begin
                        pay_reg <= {hdr_reg.length[15:8], i_rx_data};
                        if ({hdr_reg.length[15:8], i_rx_data} == 16'h0000) begin
                            rx_reg <= dfs_pkg::DFS_RX_LRC;
                        end else begin
                            rx_reg <= dfs_pkg::DFS_RX_PAY;
                        end
                    end
                end
                dfs_pkg::DFS_RX_PAY: begin
                    // Payload is only folded into the check; sector commands carry none
                    pay_reg <= pay_reg - 16'h0001;
                    if (pay_reg == 16'h0001) begin
                        rx_reg <= dfs_pkg::DFS_RX_LRC;
                    end
                end
                default: begin
                    rx_reg <= dfs_pkg::DFS_RX_IDLE;
                end
            endcase
        end
    end

    // ------------------------------
    // Command execution
    // ------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            busy_reg <= 1'b0;
            st_reg <= `DFS_ST_OK;
            op_valid_reg <= 1'b0;
            op_reg <= '0;
        end else begin
            if (rx_take && rx_reg == dfs_pkg::DFS_RX_LRC) begin
                busy_reg <= 1'b1;
                if (lrc_reg != i_rx_data) begin
                    st_reg <= `DFS_ST_BAD_LRC;
                end else if (!is_sec || !ram_ok || !fl_ok) begin
                    st_reg <= `DFS_ST_BAD_CMD;
                end else begin
                    st_reg <= `DFS_ST_OK;
                    op_valid_reg <= 1'b1;
                    op_reg.erase <= (hdr_reg.cmd == `DFS_CMD_ERASE_SEC);
                    op_reg.flash_addr <= fl_addr;
                    op_reg.ram_addr <= src_addr;
                    if (hdr_reg.cmd == `DFS_CMD_ERASE_SEC) begin
                        op_reg.flash_bytes <= `DFS_SECTOR_BYTES << 1;
                    end else begin
                        op_reg.flash_bytes <= `DFS_SECTOR_BYTES;
                    end
                end
            end
            if (op_valid_reg && i_op_ready) begin
                op_valid_reg <= 1'b0;
            end
            if (tx_reg == dfs_pkg::DFS_TX_LRC && tx_take) begin
                busy_reg <= 1'b0;
            end
            if (i_op_done && i_op_fail) begin
                st_reg <= `DFS_ST_BAD_CMD;
            end
        end
    end

    // ------------------------------
    // Response sender
    // ------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tx_reg <= dfs_pkg::DFS_TX_IDLE;
            tcnt_reg <= 2'h0;
            tlrc_reg <= 8'h00;
            tx_data_reg <= 8'h00;
        end else begin
            case (tx_reg)
                dfs_pkg::DFS_TX_IDLE: begin
                    // Answer waits for the flash engine so the status is final
                    if (busy_reg && !op_valid_reg && (i_op_done || st_reg != `DFS_ST_OK)) begin
                        tx_reg <= dfs_pkg::DFS_TX_ST;
                        tx_data_reg <= `DFS_SYNC_RSP;
                        tlrc_reg <= `DFS_SYNC_RSP;
                        tcnt_reg <= 2'h0;
                    end
                end
                dfs_pkg::DFS_TX_ST: begin
                    if (tx_take) begin
                        tcnt_reg <= tcnt_reg + 2'h1;
                        if (tcnt_reg == 2'h0) begin
                            tx_data_reg <= st_reg[15:8];
                            tlrc_reg <= tlrc_reg ^ st_reg[15:8];
                        end else if (tcnt_reg == 2'h1) begin
                            tx_data_reg <= st_reg[7:0];
                            tlrc_reg <= tlrc_reg ^ st_reg[7:0];
                        end else begin
                            tx_data_reg <= tlrc_reg;
                            tx_reg <= dfs_pkg::DFS_TX_LRC;
                        end
                    end
                end
                dfs_pkg::DFS_TX_LRC: begin
                    if (tx_take) begin
                        tx_reg <= dfs_pkg::DFS_TX_IDLE;
                    end
                end
                default: begin
                    tx_reg <= dfs_pkg::DFS_TX_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* dfs_sector_cmd_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module dfs_sector_cmd_sva (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic o_rx_ready,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    input wire logic o_op_valid,
    input wire dfs_pkg::dfs_op_t o_op,
    input wire logic i_op_ready,
    input wire logic i_op_done,
    input wire logic i_op_fail
);
    // ----
    // Checks
    // ----
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_erase_pair: assert property (o_op_valid && o_op.erase |->
        o_op.flash_bytes == 20'h02000 && o_op.flash_addr[12:0] == 13'h0) else $error("bad erase");
    a_prog_one: assert property (o_op_valid && !o_op.erase |->
        o_op.flash_bytes == 20'h01000 && o_op.flash_addr[11:0] == 12'h0) else $error("bad prog");
    a_flash_map: assert property (o_op_valid |-> o_op.flash_addr[19]) else $error("not flash");
    a_ram_low: assert property (o_op_valid |-> o_op.ram_addr[19:16] == 4'h0) else $error("ram");
    a_op_hold: assert property (o_op_valid && !i_op_ready |=>
        o_op_valid && $stable(o_op)) else $error("op dropped");
    a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=>
        o_tx_valid && $stable(o_tx_data)) else $error("tx dropped");
    a_busy_rx: assert property (o_op_valid |-> !o_rx_ready) else $error("rx open");
    a_done_sync: assert property (i_op_done |=>
        o_tx_valid && o_tx_data == 8'haa) else $error("no reply");
    a_rsp_first: assert property ($rose(o_tx_valid) |-> o_tx_data == 8'haa) else $error("sync");
    c_erase: cover property (o_op_valid && o_op.erase);
    c_prog: cover property (o_op_valid && !o_op.erase);
    c_fail: cover property (i_op_done && i_op_fail);
endmodule
bind dfs_sector_cmd dfs_sector_cmd_sva u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_rx_ready(o_rx_ready),
    .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
    .o_op_valid(o_op_valid), .o_op(o_op), .i_op_ready(i_op_ready),
    .i_op_done(i_op_done), .i_op_fail(i_op_fail));
`default_nettype wire

/* dfs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dfs_host_model (
    input wire logic i_clk,
    input wire logic i_rdy,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_valid,
    output logic [7:0] o_data,
    output logic o_tx_ready
);
    // ----
    // Link side
    // ----
    initial begin
        o_valid = 1'b0;
        o_data = 8'h00;
        o_tx_ready = 1'b0;
    end
    task automatic put(input logic [7:0] b);
        o_valid = 1'b1;
        o_data = b;
        while (!i_rdy) @(negedge i_clk);
        @(negedge i_clk);
    endtask
    // Mask e corrupts the check byte on purpose
    task automatic send(input logic [7:0] c, s, input logic [15:0] a, input logic [7:0] e);
        logic [7:0] p [7];
        p = '{8'h55, c, s, a[15:8], a[7:0], 8'h00, 8'h00};
        foreach (p[i]) put(p[i]);
        put(p[0] ^ p[1] ^ p[2] ^ p[3] ^ p[4] ^ p[5] ^ p[6] ^ e);
        o_valid = 1'b0;
        o_data = ~o_data; // Released line shows no stale byte
    endtask
    task automatic get(output logic [31:0] r);
        int k;
        k = 0;
        r = 32'h0;
        for (int n = 0; n < 400 && k < 4; n++) begin
            o_tx_ready = 1'($urandom % 2); // Random stall of the reader
            if (i_tx_valid && o_tx_ready) begin
                r = {r[23:0], i_tx_data};
                k++;
            end
            @(negedge i_clk);
        end
        o_tx_ready = 1'b0;
    endtask
endmodule
`default_nettype wire

/* dfs_sector_cmd_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dfs_sector_cmd_tb;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic rx_valid, rx_ready, tx_valid, tx_ready, op_valid;
    logic op_ready = 1'b0, op_done = 1'b0, op_fail = 1'b0;
    logic [7:0] rx_data, tx_data;
    dfs_pkg::dfs_op_t op;
    int fails = 0, n_checks = 0, cyc = 0;
    always #5 i_clk = ~i_clk;
    dfs_sector_cmd DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rx_valid(rx_valid),
        .i_rx_data(rx_data), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
        .i_tx_ready(tx_ready), .o_op_valid(op_valid), .o_op(op), .i_op_ready(op_ready),
        .i_op_done(op_done), .i_op_fail(op_fail));
    dfs_host_model u_host (.i_clk(i_clk), .i_rdy(rx_ready), .i_tx_valid(tx_valid),
        .i_tx_data(tx_data), .o_valid(rx_valid), .o_data(rx_data), .o_tx_ready(tx_ready));
    // ----
    // Helpers
    // ----
    task automatic chk(input string nm, input logic [63:0] e, g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            complete_run();
        end
    end
    // Engine answers slowly; fl makes it report failure
    task automatic run(input logic [7:0] c, s, input logic [15:0] a, input logic [7:0] e,
        input logic fl, input logic [15:0] st);
        logic [31:0] r;
        dfs_pkg::dfs_op_t x;
        x = '{c == 8'h12, 20'h80000 + {s, 12'h0}, (c == 8'h12) ? 20'h02000 : 20'h01000, {4'h0, a}};
        u_host.send(c, s, a, e);
        if (st == 16'h0 || fl) begin
            for (int n = 0; n < 50 && !op_valid; n++) @(negedge i_clk);
            chk("op", 64'(x), 64'(op));
            chk("map", 64'h3, {62'h0, op.ram_addr <= 20'h3ffff, op.flash_addr >= 20'h80000});
            repeat ($urandom % 3) @(negedge i_clk);
            op_ready = 1'b1;
            @(negedge i_clk);
            op_ready = 1'b0;
            repeat ($urandom % 4) @(negedge i_clk);
            op_done = 1'b1;
            op_fail = fl;
            @(negedge i_clk);
            op_done = 1'b0;
            op_fail = 1'b0;
        end
        u_host.get(r);
        chk("rsp", {40'h0, 8'haa, st} << 8 | 64'(8'haa ^ st[15:8] ^ st[7:0]), 64'(r));
        chk("idle op", 64'h0, 64'(op_valid));
        $display("test cmd %h sector %h done", c, s);
    endtask
    initial begin
        logic [7:0] s;
        void'($urandom(32'h2f84));
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        for (int i = 0; i < 6; i++) begin
            s = 8'($urandom % 64) << 1;
            run(8'h12, s, 16'($urandom), 8'h00, 1'b0, 16'h0);
            run(8'h13, s | 8'h01, 16'($urandom), 8'h00, 1'b0, 16'h0);
        end
        run(8'h13, 8'h7f, 16'hffff, 8'h00, 1'b0, 16'h0);
        run(8'h12, 8'h00, 16'h0000, 8'h00, 1'b0, 16'h0);
        run(8'h13, 8'h05, 16'h1234, 8'h01, 1'b0, 16'h0001);
        run(8'h11, 8'h00, 16'h0000, 8'h00, 1'b0, 16'h0002);
        run(8'h13, 8'h80, 16'h0000, 8'h00, 1'b0, 16'h0002);
        run(8'h12, 8'h02, 16'h0000, 8'h00, 1'b1, 16'h0002);
        u_host.put(8'h3c);
        run(8'h13, 8'h10, 16'h8000, 8'h00, 1'b0, 16'h0);
        complete_run();
    end
endmodule
`default_nettype wire
